// file: core/cpu_alu_pkg.sv
// Shared constants of the 8-bit core: instruction fields, core register map and resets.
package cpu_alu_pkg;

    // Instruction word and data widths.
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;

    // Instruction classes held in the top two bits of every word.
    localparam logic [1:0] CLS_FILE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;

    // Operations on a file register (bits 11:8 of a file-class word).
    localparam logic [3:0] OP_MOVWF = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUB_FILE = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_INC = 4'ha;
    localparam logic [3:0] OP_DECSZ = 4'hb;
    localparam logic [3:0] OP_RR = 4'hc;
    localparam logic [3:0] OP_RL = 4'hd;
    localparam logic [3:0] OP_SWAP = 4'he;
    localparam logic [3:0] OP_INCSZ = 4'hf;

    // Operations on an immediate constant (bits 11:8 of a literal-class word).
    localparam logic [3:0] LOP_IOR = 4'h8;
    localparam logic [3:0] LOP_AND = 4'h9;
    localparam logic [3:0] LOP_XOR = 4'ha;

    // Whole words with a fixed meaning.
    localparam logic [13:0] INSTR_NOP = 14'h0000;
    localparam logic [13:0] INSTR_RETURN = 14'h0008;

    // Core registers that live inside the datapath, by low seven address bits.
    localparam logic [6:0] ADR_INDIRECT = 7'h00;
    localparam logic [6:0] ADR_PC_LOW = 7'h02;
    localparam logic [6:0] ADR_STATUS = 7'h03;
    localparam logic [6:0] ADR_POINTER = 7'h04;
    localparam logic [6:0] ADR_PC_HIGH = 7'h0a;

    // Status register bit positions and writable bits.
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_BANK = 5;
    localparam logic [7:0] STATUS_WMASK = 8'h27;

    // Reset values.
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [4:0] PC_HIGH_RST = 5'h00;

endpackage : cpu_alu_pkg

// file: core/cpu_alu_datapath.sv
// Two-stage fetch/execute datapath of an 8-bit core with its ALU and working register.
// Summary of operation
// - Separate program and data buses.
// - Every instruction is one 14-bit word.
// - One instruction word fetched per cycle.
// - Fetch overlaps execute; two stages.
// - Non-branching instructions take one cycle.
// - Flow changes take two cycles, flushing.
// - Counter addresses 512, 1K or 2K words.
// - Program memory only on chip.
// - Core registers mapped, direct and indirect.
// - Any operation works on any register.
// - 8-bit add, subtract, shift, logic.
// - Arithmetic is two's complement.
// - Two operands: accumulator plus file/literal.
// - Single operand: accumulator or file.
// - 8-bit accumulator has no data address.
// - ALU updates carry, digit carry, zero.
// - Subtraction flags mean inverted borrow.
module cpu_alu_datapath #(
    parameter int PROG_WORDS = 2048,
    parameter int STACK_DEPTH = 8,
    localparam int PC_W = $clog2(PROG_WORDS),
    localparam int SP_W = $clog2(STACK_DEPTH)
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Program memory port, read every cycle.
    output logic [PC_W-1:0] progAddr,
    input wire logic [cpu_alu_pkg::INSTR_W-1:0] progData,
    // Data memory read port, combinational read.
    output logic [cpu_alu_pkg::ADDR_W-1:0] dataAddr,
    input wire logic [cpu_alu_pkg::DATA_W-1:0] dataRdata,
    // Data memory write port, registered.
    output logic dataWe,
    output logic [cpu_alu_pkg::ADDR_W-1:0] dataWaddr,
    output logic [cpu_alu_pkg::DATA_W-1:0] dataWdata,
    // Observation of core state.
    output logic [cpu_alu_pkg::DATA_W-1:0] wReg,
    output logic [cpu_alu_pkg::DATA_W-1:0] statusReg
);
    import cpu_alu_pkg::*;

    // Fetch stage: counter and the word fetched into the execute stage.
    logic [PC_W-1:0] pc, next_pc;
    logic [INSTR_W-1:0] ir, next_ir;
    // Core registers: accumulator, status, pointer, upper counter latch.
    logic [7:0] w, next_w;
    logic [7:0] status, next_status;
    logic [7:0] fsr, next_fsr;
    logic [4:0] pclath, next_pclath;
    // Return address stack, circular like the hardware it mirrors.
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [PC_W-1:0] next_stack [STACK_DEPTH];
    logic [SP_W-1:0] sp, next_sp;
    // Pending write to the external data memory.
    logic wrEn, next_wrEn;
    logic [7:0] wrAddr, next_wrAddr;
    logic [7:0] wrData, next_wrData;

    // Decode and ALU intermediates.
    logic [7:0] effAddr, fileIn, res, lit;
    logic [PC_W-1:0] pcm1;
    logic [9:0] sum;
    logic toW, toFile, setC, setDigit, setZ, newC, newDigit, flush;

    // Addresses served by the core itself rather than the data memory.
    function automatic logic isCore(input logic [7:0] a);
        return a[6:0] == ADR_INDIRECT || a[6:0] == ADR_PC_LOW || a[6:0] == ADR_STATUS
            || a[6:0] == ADR_POINTER || a[6:0] == ADR_PC_HIGH;
    endfunction : isCore

    // Eight-bit adder giving carry, digit carry and sum in one word.
    function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        logic [4:0] lo;
        logic [8:0] s;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {s[8], lo[4], s[7:0]};
    endfunction : addc

    // Ports driven straight from registers; dataAddr from the decoded operand address.
    // separate program bus
    assign progAddr = pc;
    assign dataWe = wrEn;
    assign dataWaddr = wrAddr;
    assign dataWdata = wrData;
    assign wReg = w;
    assign statusReg = status;
    assign dataAddr = effAddr;
    assign pcm1 = pc - 1'b1;
    assign lit = ir[7:0];

    // Operand fetch. A pending write to the same address is forwarded so that
    // back-to-back instructions see the fresh value despite the registered port.
    always_comb begin
        effAddr = (ir[6:0] == ADR_INDIRECT) ? fsr : {status[ST_BANK], ir[6:0]};
        if (effAddr[6:0] == ADR_INDIRECT) begin
            fileIn = 8'h00;
        end else if (effAddr[6:0] == ADR_PC_LOW) begin
            fileIn = pcm1[7:0];
        end else if (effAddr[6:0] == ADR_STATUS) begin
            fileIn = status;
        end else if (effAddr[6:0] == ADR_POINTER) begin
            fileIn = fsr;
        end else if (effAddr[6:0] == ADR_PC_HIGH) begin
            fileIn = {3'h0, pclath};
        end else if (wrEn && wrAddr == effAddr) begin
            fileIn = wrData;
        end else begin
            fileIn = dataRdata;
        end
    end

    // Execute stage: ALU, destination choice, flags and program flow.
    always_comb begin
        res = fileIn;
        sum = 10'h000;
        toW = 1'b0;
        toFile = 1'b0;
        setC = 1'b0;
        setDigit = 1'b0;
        setZ = 1'b0;
        newC = 1'b0;
        newDigit = 1'b0;
        flush = 1'b0;
        next_pc = pc + 1'b1;
        next_sp = sp;
        next_stack = stack;
        next_ir = progData;
        case (ir[13:12])
            CLS_FILE: begin
                toW = !ir[7];
                toFile = ir[7];
                case (ir[11:8])
                    OP_MOVWF: begin
                        res = w;
                        toW = 1'b0;
                        if (ir == INSTR_RETURN) begin
                            next_sp = sp - 1'b1;
                            next_pc = stack[next_sp];
                            flush = 1'b1;
                        end
                    end
                    OP_CLR: begin
                        res = 8'h00;
                        setZ = 1'b1;
                    end
                    OP_SUB_FILE: begin
                        sum = addc(fileIn, ~w, 1'b1);
                        res = sum[7:0];
                        setC = 1'b1;
                        setDigit = 1'b1;
                        setZ = 1'b1;
                    end
                    OP_DEC: begin
                        res = fileIn - 8'h01;
                        setZ = 1'b1;
                    end
                    OP_IOR: begin
                        res = fileIn | w;
                        setZ = 1'b1;
                    end
                    OP_AND: begin
                        res = fileIn & w;
                        setZ = 1'b1;
                    end
                    OP_XOR: begin
                        res = fileIn ^ w;
                        setZ = 1'b1;
                    end
                    OP_ADD: begin
                        sum = addc(fileIn, w, 1'b0);
                        res = sum[7:0];
                        setC = 1'b1;
                        setDigit = 1'b1;
                        setZ = 1'b1;
                    end
                    OP_MOV: begin
                        setZ = 1'b1;
                    end
                    OP_COM: begin
                        res = ~fileIn;
                        setZ = 1'b1;
                    end
                    OP_INC: begin
                        res = fileIn + 8'h01;
                        setZ = 1'b1;
                    end
                    OP_DECSZ, OP_INCSZ: begin
                        res = (ir[11:8] == OP_INCSZ) ? fileIn + 8'h01 : fileIn - 8'h01;
                        flush = (res == 8'h00);
                    end
                    OP_RR: begin
                        res = {status[ST_CARRY], fileIn[7:1]};
                        setC = 1'b1;
                        sum[9] = fileIn[0];
                    end
                    OP_RL: begin
                        res = {fileIn[6:0], status[ST_CARRY]};
                        setC = 1'b1;
                        sum[9] = fileIn[7];
                    end
                    default: begin
                        res = {fileIn[3:0], fileIn[7:4]};
                    end
                endcase
            end
            CLS_BIT: begin
                case (ir[11:10])
                    2'h0: begin
                        res = fileIn & ~(8'h01 << ir[9:7]);
                        toFile = 1'b1;
                    end
                    2'h1: begin
                        res = fileIn | (8'h01 << ir[9:7]);
                        toFile = 1'b1;
                    end
                    2'h2: flush = !fileIn[ir[9:7]];
                    default: flush = fileIn[ir[9:7]];
                endcase
            end
            CLS_JUMP: begin
                flush = 1'b1;
                if (ir[11]) begin
                    next_stack[sp] = pc;
                    next_sp = sp + 1'b1;
                end
                next_pc = PC_W'({pclath[4:3], ir[10:0]});
            end
            default: begin
                toW = 1'b1;
                case (ir[11:8])
                    LOP_IOR: begin
                        res = lit | w;
                        setZ = 1'b1;
                    end
                    LOP_AND: begin
                        res = lit & w;
                        setZ = 1'b1;
                    end
                    LOP_XOR: begin
                        res = lit ^ w;
                        setZ = 1'b1;
                    end
                    4'hc, 4'hd, 4'he, 4'hf: begin
                        sum = ir[9] ? addc(lit, w, 1'b0) : addc(lit, ~w, 1'b1);
                        res = sum[7:0];
                        setC = 1'b1;
                        setDigit = 1'b1;
                        setZ = 1'b1;
                    end
                    4'h4, 4'h5, 4'h6, 4'h7: begin
                        // Return with a constant in the accumulator.
                        res = lit;
                        next_sp = sp - 1'b1;
                        next_pc = stack[next_sp];
                        flush = 1'b1;
                    end
                    default: res = lit;
                endcase
            end
        endcase
        newDigit = sum[8];
        newC = sum[9];
        // Writing the low counter byte is a flow change as well.
        if (toFile && effAddr[6:0] == ADR_PC_LOW) begin
            next_pc = PC_W'({pclath, res});
            flush = 1'b1;
        end
        if (flush) begin
            next_ir = INSTR_NOP;
        end
    end

    // Register updates chosen by the destination and the flag set.
    always_comb begin
        next_w = toW ? res : w;
        next_fsr = fsr;
        next_pclath = pclath;
        next_status = status;
        next_wrEn = 1'b0;
        next_wrAddr = wrAddr;
        next_wrData = wrData;
        if (toFile && isCore(effAddr)) begin
            if (effAddr[6:0] == ADR_STATUS) begin
                next_status = res & STATUS_WMASK;
            end else if (effAddr[6:0] == ADR_POINTER) begin
                next_fsr = res;
            end else if (effAddr[6:0] == ADR_PC_HIGH) begin
                next_pclath = res[4:0];
            end
        end else if (toFile) begin
            next_wrEn = 1'b1;
            next_wrAddr = effAddr;
            next_wrData = res;
        end
        // Flag updates win over a direct write of the status register.
        // flag update
        if (setC) begin
            next_status[ST_CARRY] = newC;
        end
        if (setDigit) begin
            next_status[ST_DIGIT] = newDigit;
        end
        if (setZ) begin
            next_status[ST_ZERO] = (res == 8'h00);
        end
    end

    // State registers; every instruction retires in one edge.
    // single-cycle retire
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc <= '0;
            ir <= INSTR_NOP;
            w <= W_RST;
            status <= STATUS_RST;
            fsr <= POINTER_RST;
            pclath <= PC_HIGH_RST;
            sp <= '0;
            stack <= '{default: '0};
            wrEn <= 1'b0;
            wrAddr <= 8'h00;
            wrData <= 8'h00;
        end else begin
            pc <= next_pc;
            ir <= next_ir;
            w <= next_w;
            status <= next_status;
            fsr <= next_fsr;
            pclath <= next_pclath;
            sp <= next_sp;
            stack <= next_stack;
            wrEn <= next_wrEn;
            wrAddr <= next_wrAddr;
            wrData <= next_wrData;
        end
    end

endmodule : cpu_alu_datapath

// file: tb/cpu_alu_datapath_props.sv
// Port-level checker of the core datapath, bound to its top module.
module cpu_alu_datapath_props #(
    parameter int PROG_WORDS = 2048,
    localparam int PC_W = $clog2(PROG_WORDS)
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Program bus.
    input wire logic [PC_W-1:0] progAddr,
    input wire logic [cpu_alu_pkg::INSTR_W-1:0] progData,
    // Data bus.
    input wire logic [cpu_alu_pkg::ADDR_W-1:0] dataAddr,
    input wire logic [cpu_alu_pkg::DATA_W-1:0] dataRdata,
    input wire logic dataWe,
    input wire logic [cpu_alu_pkg::ADDR_W-1:0] dataWaddr,
    input wire logic [cpu_alu_pkg::DATA_W-1:0] dataWdata,
    // Core state.
    input wire logic [cpu_alu_pkg::DATA_W-1:0] wReg,
    input wire logic [cpu_alu_pkg::DATA_W-1:0] statusReg
);
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_alu_pkg::*;

    // Shadow of the executing word; known drops after a possible skip or core-register store, whose outcome is hidden.
    logic [13:0] execWord;
    logic known;
    logic [13:0] next_execWord;
    logic next_known;
    logic [3:0] op;
    logic [6:0] fField;
    logic isJump, isRet, plainF, mayBend, fresh;
    logic isMovwf, isAddF, isSubF, isLoadW;
    logic [8:0] sum9;
    logic [4:0] nibSum;
    logic [7:0] diff, litByte;
    logic noBorrow, noNibBorrow;

    // Decode of the shadow word and the expected ALU figures.
    assign op = execWord[11:8];
    assign fField = execWord[6:0];
    assign litByte = execWord[7:0];
    assign isJump = execWord[13:12] == CLS_JUMP;
    assign isRet = execWord == INSTR_RETURN || (execWord[13:12] == CLS_LIT && op[3:2] == 2'h1);
    assign plainF = !(fField inside {ADR_INDIRECT, ADR_PC_LOW, ADR_STATUS, ADR_POINTER,
        ADR_PC_HIGH});
    // Only a skip or a store into a core register bends the flow; a no-op stores nothing.
    assign mayBend = (execWord[13:12] == CLS_BIT && (execWord[11] || !plainF)) ||
        (execWord[13:12] == CLS_FILE && (op == OP_DECSZ || op == OP_INCSZ ||
        (execWord[7] && !plainF)));
    assign isMovwf = execWord[13:12] == CLS_FILE && op == OP_MOVWF && execWord[7] && plainF;
    assign isAddF = execWord[13:12] == CLS_FILE && op == OP_ADD && execWord[7] && plainF;
    assign isSubF = execWord[13:12] == CLS_FILE && op == OP_SUB_FILE && execWord[7] && plainF;
    assign isLoadW = execWord[13:12] == CLS_LIT && op[3:2] == 2'h0;
    // A write landing now on the operand is forwarded inside the core, not seen here.
    assign fresh = !(dataWe && dataWaddr == dataAddr);
    assign sum9 = {1'b0, dataRdata} + {1'b0, wReg};
    assign nibSum = {1'b0, dataRdata[3:0]} + {1'b0, wReg[3:0]};
    assign diff = dataRdata - wReg;
    assign noBorrow = dataRdata >= wReg;
    assign noNibBorrow = dataRdata[3:0] >= wReg[3:0];

    // Next shadow word: a flow change replaces the fetched word by a no-op.
    always_comb begin
        next_execWord = (isJump || isRet) ? INSTR_NOP : progData;
        next_known = known && !mayBend;
    end

    // Shadow registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            execWord <= INSTR_NOP;
            known <= 1'b1;
        end else begin
            execWord <= next_execWord;
            known <= next_known;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_fetch_step;
        known && !isJump && !isRet && !mayBend |=> progAddr == $past(progAddr) + 1'b1;
    endproperty
    property p_goto;
        known && isJump |=> progAddr == $past(execWord[PC_W-1:0]);
    endproperty
    property p_flush;
        known && isJump |=> !dataWe ##1 !dataWe;
    endproperty
    property p_movwf;
        known && isMovwf |=> dataWe && dataWaddr == $past(dataAddr) && dataWdata == $past(wReg);
    endproperty
    property p_add;
        known && isAddF && fresh |=> dataWe && dataWdata == $past(sum9[7:0]) &&
            statusReg[ST_CARRY] == $past(sum9[8]) && statusReg[ST_DIGIT] == $past(nibSum[4]);
    endproperty
    property p_sub;
        known && isSubF && fresh |=> dataWe && dataWdata == $past(diff) &&
            statusReg[ST_CARRY] == $past(noBorrow) && statusReg[ST_DIGIT] == $past(noNibBorrow);
    endproperty
    property p_zero;
        known && (isAddF || isSubF) |=> statusReg[ST_ZERO] == (dataWdata == 8'h00);
    endproperty
    property p_load_w;
        known && isLoadW |=> wReg == $past(litByte) && !dataWe;
    endproperty
    property p_direct_addr;
        known && execWord[13:12] == CLS_FILE && plainF && !isRet |->
            dataAddr == {statusReg[ST_BANK], fField};
    endproperty

    a_fetch_step: assert property (p_fetch_step) else $error("fetch did not advance");
    a_goto: assert property (p_goto) else $error("jump target not fetched");
    a_flush: assert property (p_flush) else $error("flushed word wrote data");
    a_movwf: assert property (p_movwf) else $error("accumulator store wrong");
    a_add: assert property (p_add) else $error("addition result or carry wrong");
    a_sub: assert property (p_sub) else $error("subtraction result or borrow wrong");
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    a_load_w: assert property (p_load_w) else $error("accumulator load wrong");
    a_direct_addr: assert property (p_direct_addr) else $error("direct address wrong");

    c_add: cover property (known && isAddF);
    c_sub: cover property (known && isSubF && !noBorrow);
    c_goto: cover property (known && isJump);
    c_forward: cover property (dataWe && dataWaddr == dataAddr);
endmodule : cpu_alu_datapath_props

bind cpu_alu_datapath cpu_alu_datapath_props #(.PROG_WORDS(PROG_WORDS)) u_props (
    .clk(clk), .rst(rst), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
    .dataRdata(dataRdata), .dataWe(dataWe), .dataWaddr(dataWaddr), .dataWdata(dataWdata),
    .wReg(wReg), .statusReg(statusReg));

// file: tb/prog_data_mem.sv
// Behavioural program store and data register file facing the core.
module prog_data_mem #(
    parameter int PROG_WORDS = 2048,
    localparam int PC_W = $clog2(PROG_WORDS)
) (
    // Clock.
    input wire logic clk,
    // Program bus.
    input wire logic [PC_W-1:0] progAddr,
    output logic [cpu_alu_pkg::INSTR_W-1:0] progData,
    // Data bus.
    input wire logic [cpu_alu_pkg::ADDR_W-1:0] dataAddr,
    output logic [cpu_alu_pkg::DATA_W-1:0] dataRdata,
    input wire logic dataWe,
    input wire logic [cpu_alu_pkg::ADDR_W-1:0] dataWaddr,
    input wire logic [cpu_alu_pkg::DATA_W-1:0] dataWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_alu_pkg::*;

    // On-chip program words. Filled at declaration, before any process runs, so that
    // the bench's loading at time zero can never be wiped out by this fill.
    logic [13:0] rom [PROG_WORDS] = '{default: INSTR_NOP};
    logic [7:0] ram [256]; // Data file, both banks.

    // Unwritten bytes hold a pattern so stale reads pass as zero only at address a5.
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'(i) ^ 8'ha5;
        end
    end

    // Places one program word before the run.
    task load_word(input int addr, input logic [13:0] word);
        rom[addr] = word;
    endtask : load_word

    // Separate buses, whole word per cycle.
    assign progData = rom[progAddr];
    assign dataRdata = ram[dataAddr];

    // Any file byte is written at the strobe edge.
    always @(posedge clk) begin
        if (dataWe === 1'b1) begin
            ram[dataWaddr] <= dataWdata;
        end
    end
endmodule : prog_data_mem

// file: tb/cpu_alu_datapath_tb.sv
// Self-checking bench: random add/subtract programs with jumps over trap words.
module cpu_alu_datapath_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_alu_pkg::*;

    localparam int PW = 2048;
    localparam int NCASE = 16;
    localparam logic [15:0] EDGE [4] = '{16'hff01, 16'h0505, 16'h0808, 16'h0310};

    // One expected data write: address, byte, fetch address then, flags.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [10:0] pc;
        logic arith;
        logic [2:0] flags;
    } note_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [10:0] progAddr;
    logic [13:0] progData;
    logic [7:0] dataAddr, dataRdata, dataWaddr, dataWdata, wReg, statusReg;
    logic dataWe;
    note_t notes[$];
    int fail_count = 0;
    int n_compared = 0;
    int progLen = 0;

    always #20 clk = ~clk;

    cpu_alu_datapath #(.PROG_WORDS(PW)) uut (.clk(clk), .rst(rst), .progAddr(progAddr),
        .progData(progData), .dataAddr(dataAddr), .dataRdata(dataRdata), .dataWe(dataWe),
        .dataWaddr(dataWaddr), .dataWdata(dataWdata), .wReg(wReg), .statusReg(statusReg));
    prog_data_mem #(.PROG_WORDS(PW)) mem (.clk(clk), .progAddr(progAddr), .progData(progData),
        .dataAddr(dataAddr), .dataRdata(dataRdata), .dataWe(dataWe), .dataWaddr(dataWaddr),
        .dataWdata(dataWdata));

    // Compares one value and counts it.
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Appends one word to the program.
    task emit(input logic [13:0] word);
        mem.load_word(progLen, word);
        progLen++;
    endtask : emit

    // Notes the write of the word about to be emitted; it lands two fetches later.
    task expect_write(input logic [7:0] addr, data, input logic arith, input logic [2:0] fl);
        notes.push_back('{addr, data, 11'(progLen + 2), arith, fl});
    endtask : expect_write

    task wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Builds the program during reset, then runs it until every write is seen.
    initial begin : main
        logic [7:0] a, b, f, r, r2;
        logic [8:0] s;
        logic isSub;
        logic [2:0] fl;
        void'($urandom(92));
        for (int i = 0; i < NCASE; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            f = 8'h20 + 8'($urandom_range(79));
            // Boundary operands first: wrap to zero, equal, nibble carry, borrow.
            if (i < 4) begin
                {a, b} = EDGE[i];
            end
            isSub = i[0];
            s = isSub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
            r = s[7:0];
            fl[0] = isSub ? (a >= b) : s[8];
            fl[1] = isSub ? (a[3:0] >= b[3:0]) : (({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f);
            fl[2] = (r == 8'h00);
            emit({CLS_LIT, 4'h0, a});
            expect_write(f, a, 1'b0, 3'h0);
            emit({CLS_FILE, OP_MOVWF, 1'b1, f[6:0]});
            emit({CLS_LIT, 4'h0, b});
            expect_write(f, r, 1'b1, fl);
            emit({CLS_FILE, isSub ? OP_SUB_FILE : OP_ADD, 1'b1, f[6:0]});
            // One-operand step on the fresh result, which must come through forwarding.
            r2 = i[1] ? {r[6:0], fl[0]} : ~r;
            fl = i[1] ? {fl[2:1], r[7]} : {r2 == 8'h00, fl[1:0]};
            expect_write(f, r2, 1'b1, fl);
            emit({CLS_FILE, i[1] ? OP_RL : OP_COM, 1'b1, f[6:0]});
            // A jump over a store that must never take effect.
            if (i % 4 == 3) begin
                emit({CLS_JUMP, 1'b0, 11'(progLen + 2)});
                emit({CLS_FILE, OP_MOVWF, 1'b1, 7'h7f});
            end
        end
        emit({CLS_JUMP, 1'b0, 11'(progLen)});
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 1000 && notes.size() > 0; k++) begin
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        // Writes still owed when the limit ran out count against the run.
        check(16'(notes.size()), 16'h0000);
        wrap_up();
    end

    // Takes the oldest note on every write strobe, sampled away from the edge.
    always @(negedge clk) begin : watch
        note_t n;
        if (!rst && dataWe === 1'b1) begin
            if (notes.size() == 0) begin
                check(16'(dataWaddr), 16'hffff);
            end else begin
                n = notes.pop_front();
                check(16'(dataWaddr), 16'(n.addr));
                check(16'(dataWdata), 16'(n.data));
                check(16'(progAddr), 16'(n.pc));
                if (n.arith) begin
                    check(16'({statusReg[ST_ZERO], statusReg[ST_DIGIT], statusReg[ST_CARRY]}),
                        16'(n.flags));
                end
            end
        end
    end

    // Cuts a hang short well beyond the expected ninety-odd cycles.
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
endmodule : cpu_alu_datapath_tb
